// ===== iopu_pkg.sv
/*
 Shared constants for the three-port general purpose I/O block: register
 offsets, implemented-bit masks, reset values and field positions.
 Assumes an 8-bit register address space reached from the core.
*/
package iopu_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_PORT0_DATA = 8'hd0;
	localparam logic [7:0] OFS_PORT1_DATA = 8'hd1;
	localparam logic [7:0] OFS_PORT5_DATA = 8'hd5;
	localparam logic [7:0] OFS_PORT0_DIR = 8'hb8;
	localparam logic [7:0] OFS_PORT1_DIR = 8'hc1;
	localparam logic [7:0] OFS_PORT5_DIR = 8'hc5;
	localparam logic [7:0] OFS_PORT0_PULLUP = 8'he0;
	localparam logic [7:0] OFS_PORT1_PULLUP = 8'he1;
	localparam logic [7:0] OFS_PORT5_PULLUP = 8'he5;
	localparam logic [7:0] OFS_OPEN_DRAIN = 8'he9;

	// Pin counts per port
	localparam int PORT0_PINS = 1;
	localparam int PORT1_PINS = 6;
	localparam int PORT5_PINS = 8;

	// Bits software may change; port 1 bit 5 is the input-only pin
	localparam logic [7:0] PORT0_MASK = 8'h01;
	localparam logic [7:0] PORT1_MASK = 8'h1f;
	localparam logic [7:0] PORT5_MASK = 8'hff;
	localparam logic [7:0] OPEN_DRAIN_MASK = 8'h01;

	// Field positions
	localparam int OPEN_DRAIN_SELECT_BIT = 0;
	localparam int INPUT_ONLY_PIN_BIT = 5;

	// Values after reset
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_PORT1_FIXED = 8'h20;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

endpackage

// ===== iopu_pad.sv
/*
 Registered pad control for one port: turns latch, direction, pull-up
 and open-drain settings into pin output, output enable and pull-up switch.
 Assumes the pad wire level is resolved outside from these three signals.
*/
`timescale 1ns/100ps
module iopu_pad
	import iopu_pkg::*;
#(
	parameter int PINS = 8
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [PINS-1:0] out_latch,
	input wire logic [PINS-1:0] dir_out,
	input wire logic [PINS-1:0] pullup_bit,
	input wire logic [PINS-1:0] open_drain,
	input wire logic [PINS-1:0] input_only,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pullup_on
);

	logic [PINS-1:0] next_oe;

	// Open drain only ever drives low; a high releases the pin
	always_comb
	begin
		next_oe = dir_out & ~input_only & ~(open_drain & out_latch);
	end

	// Registered so the pins never glitch on decode
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_out <= '0;
			pin_oe <= '0;
			pullup_on <= '0;
		end
		else
		begin
			pin_out <= out_latch & ~open_drain;
			pin_oe <= next_oe;
			pullup_on <= pullup_bit & ~dir_out & ~input_only;
		end
	end

endmodule // iopu_pad

// ===== iopu_port.sv
/*
 Three-port general purpose I/O block: data latches, direction, write-only
 pull-up enables and the open-drain select of port 1 pin 0, plus pin readback.
 Assumes a single-cycle core register port and synchronous pin inputs.
*/
`timescale 1ns/100ps
module iopu_port
	import iopu_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic bit_set,
	input wire logic bit_clear,
	input wire logic [2:0] bit_index,
	output logic [DATA_W-1:0] rdata,
	input wire logic ext_reset_option,
	input wire logic [PORT0_PINS-1:0] p0_pin_in,
	output logic [PORT0_PINS-1:0] p0_pin_out,
	output logic [PORT0_PINS-1:0] p0_pin_oe,
	output logic [PORT0_PINS-1:0] p0_pullup_on,
	input wire logic [PORT1_PINS-1:0] p1_pin_in,
	output logic [PORT1_PINS-1:0] p1_pin_out,
	output logic [PORT1_PINS-1:0] p1_pin_oe,
	output logic [PORT1_PINS-1:0] p1_pullup_on,
	input wire logic [PORT5_PINS-1:0] p5_pin_in,
	output logic [PORT5_PINS-1:0] p5_pin_out,
	output logic [PORT5_PINS-1:0] p5_pin_oe,
	output logic [PORT5_PINS-1:0] p5_pullup_on
);

	logic [7:0] port0_data;
	logic [7:0] port1_data;
	logic [7:0] port5_data;
	logic [7:0] port0_dir;
	logic [7:0] port1_dir;
	logic [7:0] port5_dir;
	logic [7:0] port0_pullup_enable;
	logic [7:0] port1_pullup_enable;
	logic [7:0] port5_pullup_enable;
	logic [7:0] open_drain_control;
	logic [7:0] pin_read0;
	logic [7:0] pin_read1;
	logic [7:0] pin_read5;
	logic [7:0] next_rdata;
	logic [PORT1_PINS-1:0] p1_od;
	logic [PORT1_PINS-1:0] p1_input_only;

	// Whole-byte write or single-bit change, masked to writable bits
	function automatic logic [7:0] reg_update(input logic [7:0] old, input logic [7:0] mask,
		input logic [ADDR_W-1:0] ofs);
		logic [7:0] sel;
		logic [7:0] val;
		sel = 8'h01 << bit_index;
		val = old;
		if (wr_en && addr == ofs)
			val = (old & ~mask) | (wdata & mask);
		else if (bit_set && addr == ofs)
			val = old | (sel & mask);
		else if (bit_clear && addr == ofs)
			val = old & ~(sel & mask);
		return val;
	endfunction

	// Output latches of the three ports
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			port0_data <= RST_DATA;
			port1_data <= RST_DATA;
			port5_data <= RST_DATA;
		end
		else
		begin
			port0_data <= reg_update(port0_data, PORT0_MASK, OFS_PORT0_DATA);
			port1_data <= reg_update(port1_data, PORT1_MASK, OFS_PORT1_DATA);
			port5_data <= reg_update(port5_data, PORT5_MASK, OFS_PORT5_DATA);
		end
	end

	// Direction bits; the input-only pin holds no writable bit
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			port0_dir <= RST_DIR;
			port1_dir <= RST_DIR;
			port5_dir <= RST_DIR;
		end
		else
		begin
			port0_dir <= reg_update(port0_dir, PORT0_MASK, OFS_PORT0_DIR);
			port1_dir <= reg_update(port1_dir, PORT1_MASK, OFS_PORT1_DIR);
			port5_dir <= reg_update(port5_dir, PORT5_MASK, OFS_PORT5_DIR);
		end
	end

	// Pull-up enables: byte writes only, the fixed bit always one
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			port0_pullup_enable <= RST_PULLUP;
			port1_pullup_enable <= RST_PORT1_FIXED;
			port5_pullup_enable <= RST_PULLUP;
		end
		else if (wr_en)
		begin
			if (addr == OFS_PORT0_PULLUP)
				port0_pullup_enable <= wdata & PORT0_MASK;
			if (addr == OFS_PORT1_PULLUP)
				port1_pullup_enable <= (wdata & PORT1_MASK) | RST_PORT1_FIXED;
			if (addr == OFS_PORT5_PULLUP)
				port5_pullup_enable <= wdata & PORT5_MASK;
		end
	end

	// Open-drain select; bit ops would read back zero, so only byte writes count
	always_ff @(posedge clk)
	begin
		if (reset)
			open_drain_control <= RST_OPEN_DRAIN;
		else if (wr_en && addr == OFS_OPEN_DRAIN)
			open_drain_control <= wdata & OPEN_DRAIN_MASK;
	end

	// Pin readback; input-only pin forced high under the reset option
	always_comb
	begin
		pin_read0 = 8'(p0_pin_in);
		pin_read1 = 8'(p1_pin_in);
		if (ext_reset_option)
			pin_read1[INPUT_ONLY_PIN_BIT] = 1'b1;
		pin_read5 = 8'(p5_pin_in);
	end

	// Read decode; write-only and unmapped offsets return zero
	always_comb
	begin
		case (addr)
			OFS_PORT0_DATA: next_rdata = pin_read0 & PORT0_MASK;
			OFS_PORT1_DATA: next_rdata = pin_read1 & (PORT1_MASK | RST_PORT1_FIXED);
			OFS_PORT5_DATA: next_rdata = pin_read5;
			OFS_PORT0_DIR: next_rdata = port0_dir;
			OFS_PORT1_DIR: next_rdata = port1_dir | RST_PORT1_FIXED;
			OFS_PORT5_DIR: next_rdata = port5_dir;
			default: next_rdata = READ_NONE;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset)
			rdata <= READ_NONE;
		else if (rd_en)
			rdata <= next_rdata;
		else
			rdata <= READ_NONE;
	end

	// Only pin 0 of port 1 gets the open-drain option
	always_comb
	begin
		p1_od = '0;
		p1_od[0] = open_drain_control[OPEN_DRAIN_SELECT_BIT];
		p1_input_only = '0;
		p1_input_only[INPUT_ONLY_PIN_BIT] = 1'b1;
	end

	// Pad control per port
	iopu_pad #(.PINS(PORT0_PINS)) u_pad0 (
		.clk(clk),
		.reset(reset),
		.out_latch(port0_data[PORT0_PINS-1:0]),
		.dir_out(port0_dir[PORT0_PINS-1:0]),
		.pullup_bit(port0_pullup_enable[PORT0_PINS-1:0]),
		.open_drain({PORT0_PINS{1'b0}}),
		.input_only({PORT0_PINS{1'b0}}),
		.pin_out(p0_pin_out),
		.pin_oe(p0_pin_oe),
		.pullup_on(p0_pullup_on)
	);

	iopu_pad #(.PINS(PORT1_PINS)) u_pad1 (
		.clk(clk),
		.reset(reset),
		.out_latch(port1_data[PORT1_PINS-1:0]),
		.dir_out(port1_dir[PORT1_PINS-1:0]),
		.pullup_bit(port1_pullup_enable[PORT1_PINS-1:0]),
		.open_drain(p1_od),
		.input_only(p1_input_only),
		.pin_out(p1_pin_out),
		.pin_oe(p1_pin_oe),
		.pullup_on(p1_pullup_on)
	);

	iopu_pad #(.PINS(PORT5_PINS)) u_pad5 (
		.clk(clk),
		.reset(reset),
		.out_latch(port5_data[PORT5_PINS-1:0]),
		.dir_out(port5_dir[PORT5_PINS-1:0]),
		.pullup_bit(port5_pullup_enable[PORT5_PINS-1:0]),
		.open_drain({PORT5_PINS{1'b0}}),
		.input_only({PORT5_PINS{1'b0}}),
		.pin_out(p5_pin_out),
		.pin_oe(p5_pin_oe),
		.pullup_on(p5_pullup_on)
	);

	// Checks on the behaviour above
	AST_PULLUP_RESET: assert property (@(posedge clk) reset |=>
		(port0_pullup_enable == RST_PULLUP && port5_pullup_enable == RST_PULLUP))
		else $error("pull-up enables not cleared by reset");

	AST_FIXED_PULLUP: assert property (@(posedge clk) disable iff (reset)
		port1_pullup_enable[INPUT_ONLY_PIN_BIT] && !p1_pullup_on[INPUT_ONLY_PIN_BIT])
		else $error("input-only pin pull-up state wrong");

	AST_OD_ONE_PIN: assert property (@(posedge clk) disable iff (reset)
		(wr_en && addr == OFS_OPEN_DRAIN) |=> open_drain_control[7:1] == 7'h00)
		else $error("open drain reached a pin other than pin 0");

	AST_OD_RELEASE: assert property (@(posedge clk) disable iff (reset)
		(open_drain_control[0] && port1_dir[0]) |=>
		(!p1_pin_out[0] && p1_pin_oe[0] == !$past(port1_data[0])))
		else $error("open drain pin drove high or failed to sink");

	AST_OD_WRITE: assert property (@(posedge clk) disable iff (reset)
		(wr_en && addr == OFS_OPEN_DRAIN) |=> open_drain_control[0] == $past(wdata[0]))
		else $error("open-drain select not taken from byte write");

	AST_OD_BIT_IGNORED: assert property (@(posedge clk) disable iff (reset)
		((bit_set || bit_clear) && addr == OFS_OPEN_DRAIN) |=> $stable(open_drain_control))
		else $error("bit operation changed open-drain control");

	AST_OD_OFF_DIR: assert property (@(posedge clk) disable iff (reset)
		!open_drain_control[0] |=> p1_pin_oe[0] == $past(port1_dir[0]))
		else $error("pin 0 of port 1 did not follow its direction");

	AST_DATA_TO_PIN: assert property (@(posedge clk) disable iff (reset)
		(wr_en && addr == OFS_PORT5_DATA) |=> ##1 p5_pin_out == $past(wdata, 2))
		else $error("port 5 write did not reach the pins");

	AST_READ_PINS: assert property (@(posedge clk) disable iff (reset)
		(rd_en && addr == OFS_PORT5_DATA) |=> rdata == $past(p5_pin_in))
		else $error("port 5 read did not return pin levels");

	AST_BIT_SET_ONLY: assert property (@(posedge clk) disable iff (reset)
		(bit_set && addr == OFS_PORT5_DATA) |=>
		port5_data == ($past(port5_data) | (8'h01 << $past(bit_index))))
		else $error("bit set touched other latches");

	AST_RESET_OPTION: assert property (@(posedge clk) disable iff (reset)
		(rd_en && addr == OFS_PORT1_DATA && ext_reset_option) |=> rdata[INPUT_ONLY_PIN_BIT])
		else $error("input-only pin not read as one");

	AST_DIR_RESET: assert property (@(posedge clk) reset |=>
		(port0_dir == RST_DIR && port1_dir == RST_DIR && port5_dir == RST_DIR))
		else $error("direction bits not cleared by reset");

	AST_NEVER_DRIVES: assert property (@(posedge clk) disable iff (reset)
		(rd_en && addr == OFS_PORT1_DIR) |=>
		(rdata[INPUT_ONLY_PIN_BIT] && !p1_pin_oe[INPUT_ONLY_PIN_BIT]))
		else $error("input-only pin direction wrong");

	AST_PULLUP_INPUT: assert property (@(posedge clk) disable iff (reset)
		p5_pullup_on == ($past(port5_pullup_enable) & ~$past(port5_dir)))
		else $error("pull-up on while pin in output mode");

endmodule // iopu_port

// ===== iopu_board.sv
/*
 Board model for one port: external drivers, an optional external pull-up
 resistor and the pad wire resolution fed back to the pin inputs.
 Assumes the pad control outputs of the I/O block on the same clock.
*/
`timescale 1ns/100ps
module iopu_board
#(
	parameter int PINS = 8,
	parameter logic [PINS-1:0] EXT_PU = '0
)
(
	input wire logic clk,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pullup_on,
	input wire logic [PINS-1:0] ext_val,
	input wire logic [PINS-1:0] ext_drive,
	output logic [PINS-1:0] pin_in
);
	logic [PINS-1:0] float_pat = '0;

	// Floating pins wander so a stale level never passes as valid
	always @(posedge clk)
		float_pat <= ~float_pat;

	// Chip drive wins, then a strong external driver, then weak pull-ups
	always_comb
		for (int i = 0; i < PINS; i++)
		begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_drive[i])
				pin_in[i] = ext_val[i];
			else if (pullup_on[i] | EXT_PU[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = float_pat[i];
		end
endmodule // iopu_board

// ===== iopu_port_tb.sv
/*
 Self-checking bench for the three-port I/O block with board models.
 Assumes the single-cycle register port and one-cycle-late pad outputs.
*/
`timescale 1ns/100ps
module iopu_port_tb
	import iopu_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic bit_set = 1'b0;
	logic bit_clear = 1'b0;
	logic [2:0] bit_index = 3'h0;
	logic ext_reset_option = 1'b0;
	logic [0:0] x0_val = 1'b0;
	logic [0:0] x0_drv = 1'b1;
	logic [5:0] x1_val = 6'h00;
	logic [5:0] x1_drv = 6'h3e;
	logic [7:0] x5_drv = 8'hff;
	logic [7:0] rdata;
	logic [0:0] p0_in, p0_out, p0_oe, p0_pu;
	logic [5:0] p1_in, p1_out, p1_oe, p1_pu;
	logic [7:0] p5_in, p5_out, p5_oe, p5_pu;
	logic [7:0] r, d, dir5;
	logic [2:0] idx;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] wo[5] = '{OFS_PORT0_PULLUP, OFS_PORT1_PULLUP, OFS_PORT5_PULLUP,
		OFS_OPEN_DRAIN, 8'h10};
	int n_errors = 0;
	int num_checks = 0;

	always #2 clk = ~clk;

	iopu_port uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .bit_set(bit_set), .bit_clear(bit_clear), .bit_index(bit_index),
		.rdata(rdata), .ext_reset_option(ext_reset_option),
		.p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_pullup_on(p0_pu),
		.p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe), .p1_pullup_on(p1_pu),
		.p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p5_pullup_on(p5_pu));

	// Port 1 pin 0 carries the open-drain pull-up; pin 5 is driven from outside
	iopu_board #(.PINS(1)) b0 (.clk(clk), .pin_out(p0_out), .pin_oe(p0_oe),
		.pullup_on(p0_pu), .ext_val(x0_val), .ext_drive(x0_drv), .pin_in(p0_in));
	iopu_board #(.PINS(6), .EXT_PU(6'h01)) b1 (.clk(clk), .pin_out(p1_out), .pin_oe(p1_oe),
		.pullup_on(p1_pu), .ext_val(x1_val), .ext_drive(x1_drv), .pin_in(p1_in));
	iopu_board b5 (.clk(clk), .pin_out(p5_out), .pin_oe(p5_oe),
		.pullup_on(p5_pu), .ext_val(r), .ext_drive(x5_drv), .pin_in(p5_in));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Gap cycle after each strobe keeps drivers single-assigned per step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
	endtask

	task automatic bop(input logic [7:0] a, input logic [2:0] i, input logic s);
		addr <= a;
		bit_index <= i;
		bit_set <= s;
		bit_clear <= ~s;
		@(posedge clk);
		bit_set <= 1'b0;
		bit_clear <= 1'b0;
		@(posedge clk);
	endtask

	// Read data stands only one cycle, so it is taken mid-cycle
	always @(posedge clk)
		rd_seen <= rd_en;
	always @(negedge clk)
		if (rd_seen)
			chk(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("unexpected %0t run did not finish", $time);
		end_sim();
	end

	initial
	begin
		void'($urandom(57861));
		r = 8'($urandom);
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Reset state of pads and readable registers
		@(negedge clk);
		chk({2'b00, p1_oe | p1_out | p1_pu} | p5_oe | p5_out | p5_pu, 8'h00);
		chk({7'h00, p0_oe | p0_out | p0_pu}, 8'h00);
		@(posedge clk);
		rd(OFS_PORT0_DATA, 8'h00);
		x0_val <= 1'b1;
		rd(OFS_PORT0_DATA, 8'h01);
		rd(OFS_PORT1_DATA, 8'h01);
		rd(OFS_PORT1_DIR, RST_PORT1_FIXED);
		rd(OFS_PORT5_DIR, RST_DIR);
		foreach (wo[i]) rd(wo[i], READ_NONE);
		// Pull-ups against a random direction mix on port 5
		wr(OFS_PORT0_PULLUP, 8'hff);
		wr(OFS_PORT1_PULLUP, 8'hff);
		wr(OFS_PORT5_PULLUP, 8'hff);
		d = 8'($urandom);
		dir5 = 8'($urandom);
		wr(OFS_PORT5_DATA, d);
		wr(OFS_PORT5_DIR, dir5);
		@(negedge clk);
		chk({7'h00, p0_pu}, 8'h01);
		chk({2'b00, p1_pu}, 8'h1f);
		chk(p5_pu, ~dir5);
		chk(p5_oe, dir5);
		chk(p5_out, d);
		@(posedge clk);
		// Released input pins must read high through the enabled pull-ups
		x0_drv <= 1'b0;
		rd(OFS_PORT0_DATA, 8'h01);
		rd(OFS_PORT5_DATA, (d & dir5) | (r & ~dir5));
		x5_drv <= 8'h00;
		rd(OFS_PORT5_DATA, (d & dir5) | ~dir5);
		x5_drv <= 8'hff;
		// All outputs on ports 0 and 1; the input-only pin never drives
		wr(OFS_PORT0_DATA, 8'hff);
		wr(OFS_PORT0_DIR, 8'hff);
		wr(OFS_PORT1_DATA, 8'hff);
		wr(OFS_PORT1_DIR, 8'hff);
		@(negedge clk);
		chk({7'h00, p0_oe & p0_out}, 8'h01);
		chk({2'b00, p1_oe}, 8'h1f);
		chk({2'b00, p1_pu}, 8'h00);
		@(posedge clk);
		rd(OFS_PORT1_DIR, 8'h3f);
		rd(OFS_PORT1_DATA, 8'h1f);
		x1_val <= 6'h20;
		rd(OFS_PORT1_DATA, 8'h3f);
		x1_val <= 6'h00;
		ext_reset_option <= 1'b1;
		rd(OFS_PORT1_DATA, 8'h3f);
		// Single-bit latch changes at random positions
		for (int k = 0; k < 6; k++)
		begin
			idx = 3'($urandom);
			bop(OFS_PORT5_DATA, idx, k[0]);
			d[idx] = k[0];
			rd(OFS_PORT5_DATA, (d & dir5) | (r & ~dir5));
			@(negedge clk);
			chk(p5_out, d);
			@(posedge clk);
		end
		bop(OFS_PORT1_DIR, 3'd2, 1'b0);
		rd(OFS_PORT1_DIR, 8'h3b);
		// Open drain with latch high releases only pin 0; whole-byte writes only
		wr(OFS_OPEN_DRAIN, 8'hff);
		bop(OFS_OPEN_DRAIN, 3'd0, 1'b0);
		@(negedge clk);
		chk({2'b00, p1_oe}, 8'h1a);
		chk({2'b00, p1_pu}, 8'h04);
		@(posedge clk);
		rd(OFS_PORT1_DATA, 8'h3b);
		bop(OFS_PORT1_DATA, 3'd0, 1'b0);
		@(negedge clk);
		chk({2'b00, p1_oe}, 8'h1b);
		chk({7'h00, p1_out[0]}, 8'h00);
		@(posedge clk);
		rd(OFS_PORT1_DATA, 8'h3a);
		bop(OFS_PORT1_DATA, 3'd0, 1'b1);
		wr(OFS_OPEN_DRAIN, 8'h00);
		@(negedge clk);
		chk({2'b00, p1_oe}, 8'h1b);
		chk({2'b00, p1_out} & 8'h1f, 8'h1f);
		@(posedge clk);
		chk(8'(exp_q.size()), 8'h00);
		end_sim();
	end
endmodule // iopu_port_tb
